// ---- common/pcdmux_pkg.sv ----
// Summary of operation
// - PC5..7: port or waveform address bits
// - port D mode: interface field plus wordwide
// - data mode: PD0..7 carry bus bits 8..15
// - PE0: port or timer0 pulse, select bit0
// - timer0 pulse high one cpu-clock cycle
// - timer0 mode 3: low byte overflow pulses
// - PE1: port or timer1 pulse, select bit1
// - timer1 pulse high one cpu-clock cycle
// - timer1 mode 3: low byte overflow pulses
// - two-bit interface field and wordwide bit pick port or bus
`default_nettype none
package pcdmux_pkg;
	// interface mode field encodings
	localparam logic [1:0] PCDMUX_IFM_PORTS = 2'h0;
	localparam logic [1:0] PCDMUX_IFM_RSVD = 2'h1;
	localparam logic [1:0] PCDMUX_IFM_WAVE = 2'h2;
	localparam logic [1:0] PCDMUX_IFM_FIFO = 2'h3;
	// select bit positions
	localparam int PCDMUX_PC_FIRST = 5;
	localparam int PCDMUX_PE_T0_BIT = 0;
	localparam int PCDMUX_PE_T1_BIT = 1;
	localparam int PCDMUX_WORDWIDE_BIT = 0;
	// timer mode with split counters
	localparam logic [1:0] PCDMUX_TMODE_SPLIT = 2'h3;
	// reset values
	localparam logic [7:0] PCDMUX_BYTE_RST = 8'h00;
	localparam logic [2:0] PCDMUX_PC_RST = 3'h0;
	localparam logic [1:0] PCDMUX_PE_RST = 2'h0;
	// pulse stretcher states
	typedef enum logic [1:0] {
		PCDMUX_P_IDLE = 2'b00,
		PCDMUX_P_WAIT = 2'b01,
		PCDMUX_P_HIGH = 2'b10
	} pcdmux_pstate_t;
endpackage : pcdmux_pkg
`default_nettype wire

// ---- rtl/pcdmux_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
// stretches one overflow event into one cpu output clock cycle high
module pcdmux_pulse
	import pcdmux_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timer events
	input wire logic ovf_full,
	input wire logic ovf_low,
	input wire logic [1:0] tmode,
	// cpu output clock phase: high on its rising edge cycle
	input wire logic cpu_clk_rise,
	// pulse out
	output logic pulse
);
	pcdmux_pstate_t st_r, st_nxt;
	logic ev;

	// pick overflow source
	always_comb begin
		if (tmode == PCDMUX_TMODE_SPLIT) begin
			ev = ovf_low;
		end else begin
			ev = ovf_full;
		end
	end

	// next state: wait for cpu clock edge, hold one cpu period
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			PCDMUX_P_IDLE: begin
				if (ev && cpu_clk_rise) begin
					st_nxt = PCDMUX_P_HIGH;
				end else if (ev) begin
					st_nxt = PCDMUX_P_WAIT;
				end
			end
			PCDMUX_P_WAIT: begin
				if (cpu_clk_rise) begin
					st_nxt = PCDMUX_P_HIGH;
				end
			end
			PCDMUX_P_HIGH: begin
				if (cpu_clk_rise) begin
					st_nxt = ev ? PCDMUX_P_HIGH : PCDMUX_P_IDLE;
				end
			end
			default: st_nxt = PCDMUX_P_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= PCDMUX_P_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pulse = (st_r == PCDMUX_P_HIGH);
endmodule : pcdmux_pulse
`default_nettype wire

// ---- rtl/pcdmux_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// pin mux for PC5..7, PD0..7, PE0..1
module pcdmux_top
	import pcdmux_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration from the processor
	input wire logic [7:0] port_c_alt_select,
	input wire logic [7:0] port_e_alt_select,
	input wire logic [1:0] interface_mode_config,
	input wire logic [7:0] endpoint_fifo_config,
	// general purpose port C upper bits
	input wire logic [2:0] port_c_out,
	input wire logic [2:0] port_c_oe,
	output logic [2:0] port_c_in,
	// general purpose port D
	input wire logic [7:0] port_d_out,
	input wire logic [7:0] port_d_oe,
	output logic [7:0] port_d_in,
	// general purpose port E low bits
	input wire logic [1:0] port_e_out,
	input wire logic [1:0] port_e_oe,
	output logic [1:0] port_e_in,
	// waveform engine address bits 5..7
	input wire logic [2:0] wave_addr_out,
	// upper data byte from engine
	input wire logic [7:0] shared_data_bus_upper_out,
	input wire logic shared_data_bus_upper_oe,
	output logic [7:0] shared_data_bus_upper_in,
	// timers
	input wire logic timer0_ovf,
	input wire logic timer0_low_ovf,
	input wire logic [1:0] timer0_mode,
	input wire logic timer1_ovf,
	input wire logic timer1_low_ovf,
	input wire logic [1:0] timer1_mode,
	input wire logic cpu_clock_output_rise,
	// pins: port C 5..7
	input wire logic [2:0] pin_c_i,
	output logic [2:0] pin_c_o,
	output logic [2:0] pin_c_oe,
	// pins: port D 0..7
	input wire logic [7:0] pin_d_i,
	output logic [7:0] pin_d_o,
	output logic [7:0] pin_d_oe,
	// pins: port E 0..1
	input wire logic [1:0] pin_e_i,
	output logic [1:0] pin_e_o,
	output logic [1:0] pin_e_oe,
	// timer pulse status
	output logic timer0_overflow_pulse,
	output logic timer1_overflow_pulse
);
	// port C upper bits: drive, enable, sampled level
	logic [2:0] c_o_r;
	logic [2:0] c_o_nxt;
	logic [2:0] c_oe_r;
	logic [2:0] c_oe_nxt;
	logic [2:0] c_in_r;
	logic [2:0] c_in_nxt;
	// port D: drive, enable, port sample, bus sample
	logic [7:0] d_o_r;
	logic [7:0] d_o_nxt;
	logic [7:0] d_oe_r;
	logic [7:0] d_oe_nxt;
	logic [7:0] d_in_r;
	logic [7:0] d_in_nxt;
	logic [7:0] fd_in_r;
	logic [7:0] fd_in_nxt;
	// port E low bits: drive, enable, sampled level
	logic [1:0] e_o_r;
	logic [1:0] e_o_nxt;
	logic [1:0] e_oe_r;
	logic [1:0] e_oe_nxt;
	logic [1:0] e_in_r;
	logic [1:0] e_in_nxt;
	// registered timer pulse copies
	logic t0_r;
	logic t0_nxt;
	logic t1_r;
	logic t1_nxt;
	// pulse former outputs
	logic t0_p;
	logic t1_p;
	// port D handed to the data bus
	logic bus_mode;
	// per-pin address selects of port C
	logic [2:0] c_alt;

	// port D belongs to the bus only in an engine mode with a word-wide endpoint
	function automatic logic pd_is_bus(input logic [1:0] ifm, input logic [7:0] fcfg);
		pd_is_bus = (ifm != PCDMUX_IFM_PORTS) && (ifm != PCDMUX_IFM_RSVD)
			&& fcfg[PCDMUX_WORDWIDE_BIT];
	endfunction : pd_is_bus

	// timer 0 pulse former
	pcdmux_pulse u_t0 (
		.clk(clk),
		.rst(rst),
		.ovf_full(timer0_ovf),
		.ovf_low(timer0_low_ovf),
		.tmode(timer0_mode),
		.cpu_clk_rise(cpu_clock_output_rise),
		.pulse(t0_p)
	);

	// timer 1 pulse former
	pcdmux_pulse u_t1 (
		.clk(clk),
		.rst(rst),
		.ovf_full(timer1_ovf),
		.ovf_low(timer1_low_ovf),
		.tmode(timer1_mode),
		.cpu_clk_rise(cpu_clock_output_rise),
		.pulse(t1_p)
	);

	// mode decode
	always_comb begin
		bus_mode = pd_is_bus(interface_mode_config, endpoint_fifo_config);
		c_alt = port_c_alt_select[PCDMUX_PC_FIRST +: 3];
	end

	// next pin values
	always_comb begin
		c_o_nxt = (c_alt & wave_addr_out) | (~c_alt & port_c_out);
		c_oe_nxt = c_alt | port_c_oe;
		// pins are sampled every cycle whatever owns them
		c_in_nxt = pin_c_i;
		if (bus_mode) begin
			// whole byte follows the one engine enable
			d_o_nxt = shared_data_bus_upper_out;
			d_oe_nxt = {8{shared_data_bus_upper_oe}};
			fd_in_nxt = pin_d_i;
		end else begin
			// plain port, bus input parked at zero
			d_o_nxt = port_d_out;
			d_oe_nxt = port_d_oe;
			fd_in_nxt = PCDMUX_BYTE_RST;
		end
		d_in_nxt = pin_d_i;
		if (port_e_alt_select[PCDMUX_PE_T0_BIT]) begin
			// timer owns the pin and always drives it
			e_o_nxt[0] = t0_p;
			e_oe_nxt[0] = 1'b1;
		end else begin
			// plain port bit
			e_o_nxt[0] = port_e_out[0];
			e_oe_nxt[0] = port_e_oe[0];
		end
		if (port_e_alt_select[PCDMUX_PE_T1_BIT]) begin
			// timer owns the pin and always drives it
			e_o_nxt[1] = t1_p;
			e_oe_nxt[1] = 1'b1;
		end else begin
			// plain port bit
			e_o_nxt[1] = port_e_out[1];
			e_oe_nxt[1] = port_e_oe[1];
		end
		e_in_nxt = pin_e_i;
		// status copies track the formers, same cycle as the pins
		t0_nxt = t0_p;
		t1_nxt = t1_p;
	end

	// register everything
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// every pin an undriven port input
			c_o_r <= PCDMUX_PC_RST;
			c_oe_r <= PCDMUX_PC_RST;
			c_in_r <= PCDMUX_PC_RST;
			d_o_r <= PCDMUX_BYTE_RST;
			d_oe_r <= PCDMUX_BYTE_RST;
			d_in_r <= PCDMUX_BYTE_RST;
			fd_in_r <= PCDMUX_BYTE_RST;
			e_o_r <= PCDMUX_PE_RST;
			e_oe_r <= PCDMUX_PE_RST;
			e_in_r <= PCDMUX_PE_RST;
			t0_r <= 1'b0;
			t1_r <= 1'b0;
		end else begin
			// take the next values every edge
			c_o_r <= c_o_nxt;
			c_oe_r <= c_oe_nxt;
			c_in_r <= c_in_nxt;
			d_o_r <= d_o_nxt;
			d_oe_r <= d_oe_nxt;
			d_in_r <= d_in_nxt;
			fd_in_r <= fd_in_nxt;
			e_o_r <= e_o_nxt;
			e_oe_r <= e_oe_nxt;
			e_in_r <= e_in_nxt;
			t0_r <= t0_nxt;
			t1_r <= t1_nxt;
		end
	end

	// outputs straight from flops
	// port C pins and sample
	assign pin_c_o = c_o_r;
	assign pin_c_oe = c_oe_r;
	assign port_c_in = c_in_r;
	// port D pins, port sample and bus sample
	assign pin_d_o = d_o_r;
	assign pin_d_oe = d_oe_r;
	assign port_d_in = d_in_r;
	assign shared_data_bus_upper_in = fd_in_r;
	// port E pins and sample
	assign pin_e_o = e_o_r;
	assign pin_e_oe = e_oe_r;
	assign port_e_in = e_in_r;
	// timer status
	assign timer0_overflow_pulse = t0_r;
	assign timer1_overflow_pulse = t1_r;
endmodule : pcdmux_top
`default_nettype wire

// ---- sim/pcdmux_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// watches the pin mux ports
module pcdmux_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic [7:0] port_c_alt_select,
	input wire logic [7:0] port_e_alt_select,
	input wire logic [7:0] endpoint_fifo_config,
	input wire logic [1:0] interface_mode_config,
	input wire logic [1:0] timer0_mode,
	input wire logic [1:0] timer1_mode,
	// user side
	input wire logic [2:0] port_c_out,
	input wire logic [2:0] port_c_oe,
	input wire logic [2:0] wave_addr_out,
	input wire logic [7:0] port_d_out,
	input wire logic [7:0] shared_data_bus_upper_out,
	input wire logic [7:0] shared_data_bus_upper_in,
	input wire logic shared_data_bus_upper_oe,
	input wire logic timer0_ovf,
	input wire logic timer1_low_ovf,
	input wire logic cpu_clock_output_rise,
	// pins and pulses
	input wire logic [2:0] pin_c_o,
	input wire logic [2:0] pin_c_oe,
	input wire logic [7:0] pin_d_i,
	input wire logic [7:0] pin_d_o,
	input wire logic [7:0] pin_d_oe,
	input wire logic [1:0] pin_e_o,
	input wire logic [1:0] pin_e_oe,
	input wire logic timer0_overflow_pulse,
	input wire logic timer1_overflow_pulse
);
	// port d in bus use
	wire logic bus = interface_mode_config[1] & endpoint_fifo_config[0];
	// address selects of pins 5..7
	wire logic [2:0] csel = port_c_alt_select[7:5];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_pc_mux: assert property (
		pin_c_o == ($past(csel) & $past(wave_addr_out) | ~$past(csel) & $past(port_c_out)))
		else $error("port c data");
	chk_pc_drive: assert property (
		pin_c_oe == ($past(csel) | $past(port_c_oe))) else $error("port c enable");
	chk_pd_bus: assert property ($past(bus) |-> pin_d_o == $past(shared_data_bus_upper_out)
		&& pin_d_oe == {8{$past(shared_data_bus_upper_oe)}}) else $error("port d bus drive");
	chk_pd_port: assert property (
		!$past(bus) |-> pin_d_o == $past(port_d_out)) else $error("port d gpio drive");
	chk_pd_read: assert property (
		$past(bus) |-> shared_data_bus_upper_in == $past(pin_d_i)) else $error("bus read");
	chk_pe_t0: assert property ($past(port_e_alt_select[0]) |-> pin_e_oe[0]
		&& pin_e_o[0] == timer0_overflow_pulse) else $error("timer0 pin");
	chk_t0_start: assert property (timer0_mode != 2'h3 && timer0_ovf && cpu_clock_output_rise
		|-> ##2 timer0_overflow_pulse) else $error("timer0 pulse missing");
	chk_t1_split: assert property (timer1_mode == 2'h3 && timer1_low_ovf && cpu_clock_output_rise
		|-> ##2 timer1_overflow_pulse) else $error("timer1 split pulse missing");
	chk_t0_edges: assert property (
		$changed(timer0_overflow_pulse) |-> $past(cpu_clock_output_rise, 2)) else $error("t0 width");
	chk_t1_edges: assert property (
		$changed(timer1_overflow_pulse) |-> $past(cpu_clock_output_rise, 2)) else $error("t1 width");
	// main scenarios
	cover property ($rose(timer0_overflow_pulse));
	cover property ($rose(timer1_overflow_pulse));
	cover property (bus);
endmodule : pcdmux_asserts
`default_nettype wire

// ---- sim/pcdmux_far.sv ----
`timescale 1ns/1ps
`default_nettype none
// far logic on the shared pins, {c, d, e}
module pcdmux_far (
	// device drive
	input wire logic [12:0] pin_o,
	input wire logic [12:0] pin_oe,
	// value the far logic offers
	input wire logic [12:0] far_val,
	// resolved pin level
	output logic [12:0] pin_i
);
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & far_val);
endmodule : pcdmux_far
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// pin mux bench
module testbench import pcdmux_pkg::*;;
	// design inputs
	logic clk = 0, rst = 1, shared_data_bus_upper_oe = 0, cpu_clock_output_rise = 0;
	logic timer0_ovf = 0, timer0_low_ovf = 0, timer1_ovf = 0, timer1_low_ovf = 0;
	logic [7:0] port_c_alt_select = '0, port_e_alt_select = '0, endpoint_fifo_config = '0;
	logic [7:0] port_d_out = '0, port_d_oe = 8'h0f, shared_data_bus_upper_out = '0;
	logic [2:0] port_c_out = '0, port_c_oe = '0, wave_addr_out = '0;
	logic [1:0] port_e_out = '0, port_e_oe = '0, interface_mode_config = '0;
	logic [1:0] timer0_mode = '0, timer1_mode = '0;
	// design outputs
	logic [7:0] shared_data_bus_upper_in, port_d_in, pin_d_o, pin_d_oe;
	logic [2:0] port_c_in, pin_c_o, pin_c_oe;
	logic [1:0] port_e_in, pin_e_o, pin_e_oe;
	logic timer0_overflow_pulse, timer1_overflow_pulse;
	// resolved pins and far value
	wire logic [2:0] pin_c_i;
	wire logic [7:0] pin_d_i;
	wire logic [1:0] pin_e_i;
	logic [12:0] far_val = {3'h1, 8'h96, 2'h2};
	int fail_count = 0, compares = 0, n0, n1;
	logic [7:0] cyc = '0;
	// expected port C enable and drive of a row
	logic [2:0] c_oe_x, c_o_x;
	// rows: {bus expected, wordwide, mode, address selects}
	logic [6:0] rows [6] = '{7'h20, 7'h2d, 7'h12, 7'h76, 7'h7b, 7'h1c};
	pcdmux_top i_pcdmux_top (.*);
	pcdmux_far i_pcdmux_far (.pin_o({pin_c_o, pin_d_o, pin_e_o}),
		.pin_oe({pin_c_oe, pin_d_oe, pin_e_oe}), .far_val(far_val),
		.pin_i({pin_c_i, pin_d_i, pin_e_i}));
	// clock
	initial forever #2.5 clk = ~clk;
	// cpu output clock: a rise every fourth cycle
	always @(posedge clk) begin
		cyc <= cyc + 8'h1;
		cpu_clock_output_rise <= cyc[1:0] == 2'h3;
	end
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		if (fail_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	// timer events lag cycles after a rise, then count pulse plus pin high cycles
	task automatic fire(input logic [3:0] ev, input int lag);
		@(posedge clk iff cyc[1:0] == 2'h3);
		repeat (lag) @(posedge clk);
		{timer0_ovf, timer0_low_ovf, timer1_ovf, timer1_low_ovf} <= ev;
		@(posedge clk);
		{timer0_ovf, timer0_low_ovf, timer1_ovf, timer1_low_ovf} <= 4'h0;
		n0 = 0;
		n1 = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			n0 += timer0_overflow_pulse + pin_e_o[0];
			n1 += timer1_overflow_pulse + pin_e_o[1];
		end
	endtask : fire
	initial begin
		repeat (11) @(posedge clk);
		#1;
		chk({pin_c_oe, pin_d_oe, pin_e_oe, timer0_overflow_pulse}, 16'h0);
		@(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			{interface_mode_config, port_c_alt_select[7:5]} <= rows[i][4:0];
			endpoint_fifo_config[0] <= rows[i][5];
			shared_data_bus_upper_oe <= rows[i][0];
			port_c_out <= 3'(i);
			port_c_oe <= 3'(i);
			wave_addr_out <= ~3'(i);
			port_d_out <= 8'(i * 3);
			shared_data_bus_upper_out <= 8'(i) ^ 8'ha5;
			{port_e_out, port_e_oe} <= {2'(i), 2'(i)};
			repeat (3) @(posedge clk);
			#1;
			chk(pin_c_o, rows[i][2:0] & ~3'(i) | ~rows[i][2:0] & 3'(i));
			chk(pin_c_oe, rows[i][2:0] | 3'(i));
			chk(pin_d_o, rows[i][6] ? 8'(i) ^ 8'ha5 : 8'(i * 3));
			chk(pin_d_oe, rows[i][6] ? {8{rows[i][0]}} : 8'h0f);
			chk(shared_data_bus_upper_in, !rows[i][6] ? 8'h0 : rows[i][0] ? 8'(i) ^ 8'ha5 : 8'h96);
			chk({pin_e_o, pin_e_oe}, {2'(i), 2'(i)});
			c_oe_x = rows[i][2:0] | 3'(i);
			c_o_x = rows[i][2:0] & ~3'(i) | ~rows[i][2:0] & 3'(i);
			chk(port_c_in, c_oe_x & c_o_x | ~c_oe_x & 3'h1);
			chk(port_d_in, !rows[i][6] ? 8'(i * 3) & 8'h0f | 8'h90
				: rows[i][0] ? 8'(i) ^ 8'ha5 : 8'h96);
			chk(port_e_in, 2'(i) | ~2'(i) & 2'h2);
		end
		@(posedge clk);
		port_e_alt_select <= 8'h03;
		timer1_mode <= PCDMUX_TMODE_SPLIT;
		fire(4'ha, 0);
		chk(16'(n0), 16'h8);
		chk(16'(n1), 16'h0);
		fire(4'h5, 0);
		chk(16'(n0), 16'h0);
		chk(16'(n1), 16'h8);
		chk(pin_e_oe, 2'h3);
		// event between rises waits for the next rise
		@(posedge clk);
		timer0_mode <= PCDMUX_TMODE_SPLIT;
		fire(4'h4, 1);
		chk(16'(n0), 16'h8);
		chk(16'(n1), 16'h0);
		final_report;
	end
	// watchdog
	initial begin
		#2us;
		fail_count++;
		final_report;
	end
endmodule : testbench
bind pcdmux_top pcdmux_asserts i_pcdmux_asserts (.*);
`default_nettype wire
